/* rtl/mctc_top.sv */
`timescale 1ns/1ps
// What this block does
// (RL1) Modify op ORs register pair into next word
// (RL2) Pair drives bus with next word, unchanged
// (RL3) Compare literal: A minus literal, status only
// (RL4) Compare sets sign, zero, half carry, carry
// (RL5) Compare byte: A minus B, flags form
// (RL6) Flags forms set N, Z, V, C
// (RL7) Compare word: 16-bit pairs subtracted
// (RL8) Word forms take sign, zero from 16 bits
// (RL9) Test literal: AND, sign and zero only
// (RL10) Test byte: AND, one microcycle
// (RL11) Test flags forms: N Z, V cleared
// (RL12) Test word: AND 16-bit pairs
// (RL13) Plain forms keep codes; sources untouched
// (RL14) Clear selected internal interrupt flags
// (RL15) Set selected internal interrupt flags
// (RL16) B field codes select flags, any combination
// (RL17) Clear translation state bits
// (RL18) Microprogram leaves translation bits zero
// (RL19) Idle op changes nothing, one microcycle
// (RL20) Sign and zero from one result, same cycle
module mctc_top (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Control store word, one per microcycle
    input wire logic [15:0] cs_word_i,
    input wire logic cs_valid_i,
    // Executed word and state
    output logic [15:0] instruction_bus_o,
    output logic exec_valid_o,
    output logic [3:0] status_bits_o,
    output logic [3:0] cond_codes_o,
    output logic [2:0] irq_flags_o,
    output logic [2:0] translation_state_bits_o,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // Whole state of the block
    typedef struct packed {
        logic [15:0][7:0] rf;   // Register file
        logic [3:0] stat;       // Sign zero half carry carry
        logic [3:0] cc;         // N Z V C
        logic [2:0] irq;        // Internal interrupt flags
        logic [2:0] xst;        // Translation state bits
        logic en;               // Execution enable
        logic mod_pend;         // Pair waits to merge
        logic [15:0] mod_word;  // Captured pair
        logic [15:0] ibus;      // Last executed word
        logic ex_vld;           // Executed pulse
        logic aw_have;          // Write address held
        logic [7:0] aw_addr;
        logic w_have;           // Write data held
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awrdy;
        logic wrdy;
        logic bvld;
        logic [1:0] bresp;
        logic arrdy;
        logic rvld;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mctc_state_t;

    mctc_state_t q;   // Registered state
    mctc_state_t d;   // Next state

    // Datapath intermediates
    logic [15:0] word;       // Effective word after merge
    mctc_pkg::mctc_op_t op;  // Decoded class
    logic flg_form;          // Updates condition codes
    logic is_word;           // 16-bit operands
    logic [3:0] a_idx;
    logic [3:0] b_idx;
    logic [3:0] a_hi;
    logic [3:0] b_hi;
    logic [15:0] x;          // Minuend / AND operand
    logic [15:0] y;          // Subtrahend / AND operand
    logic [16:0] diff;       // Difference with borrow
    logic [4:0] nib;         // Low nibble difference
    logic [15:0] res;        // Single result for flags
    logic sgn_x;
    logic sgn_y;
    logic neg;
    logic zero;
    logic ovf;
    logic borrow;
    logic half;
    logic fire;              // A word executes now
    logic [2:0] sel;         // Selected interrupt flags
    logic [7:0] wa;
    logic [7:0] ra;

    // Decode the effective word into an operation class
    always_comb begin
        op = mctc_pkg::OP_NONE;
        flg_form = 1'b0;
        if (word[15:12] == mctc_pkg::OPC_CMP_LIT) begin
            op = mctc_pkg::OP_CMP_LIT;
        end else if (word[15:12] == mctc_pkg::OPC_TST_LIT) begin
            op = mctc_pkg::OP_TST_LIT;
        end else begin
            case (word[15:8])
                mctc_pkg::OPC_MODIFY: op = mctc_pkg::OP_MODIFY;
                mctc_pkg::OPC_CMP_B: op = mctc_pkg::OP_CMP_B;
                mctc_pkg::OPC_CMP_BF: begin
                    op = mctc_pkg::OP_CMP_B;
                    flg_form = 1'b1;
                end
                mctc_pkg::OPC_CMP_W: op = mctc_pkg::OP_CMP_W;
                mctc_pkg::OPC_CMP_WF: begin
                    op = mctc_pkg::OP_CMP_W;
                    flg_form = 1'b1;
                end
                mctc_pkg::OPC_TST_B: op = mctc_pkg::OP_TST_B;
                mctc_pkg::OPC_TST_BF: begin
                    op = mctc_pkg::OP_TST_B;
                    flg_form = 1'b1;
                end
                mctc_pkg::OPC_TST_W: op = mctc_pkg::OP_TST_W;
                mctc_pkg::OPC_TST_WF: begin
                    op = mctc_pkg::OP_TST_W;
                    flg_form = 1'b1;
                end
                mctc_pkg::OPC_CLR_IRQ: op = mctc_pkg::OP_CLR_IRQ;
                mctc_pkg::OPC_SET_IRQ: op = mctc_pkg::OP_SET_IRQ;
                mctc_pkg::OPC_CLR_XST: op = mctc_pkg::OP_CLR_XST;
                mctc_pkg::OPC_IDLE: op = mctc_pkg::OP_IDLE;
                default: op = mctc_pkg::OP_NONE;
            endcase
        end
    end

    // Operand fetch and a single shared result
    always_comb begin
        // Merge held pair with the following word [RL1] [RL2]
        word = cs_word_i | (q.mod_pend ? q.mod_word : 16'h0000);
        fire = cs_valid_i & q.en;
        a_idx = word[3:0];
        b_idx = word[7:4];
        a_hi = a_idx + 4'h1;
        b_hi = b_idx + 4'h1;
        is_word = (op == mctc_pkg::OP_CMP_W) || (op == mctc_pkg::OP_TST_W);
        x = {8'h00, q.rf[a_idx]};
        y = {8'h00, q.rf[b_idx]};
        if (is_word) begin
            // Pairs A+1:A and B+1:B [RL7] [RL12]
            x = {q.rf[a_hi], q.rf[a_idx]};
            y = {q.rf[b_hi], q.rf[b_idx]};
        end else if (op == mctc_pkg::OP_CMP_LIT ||
                     op == mctc_pkg::OP_TST_LIT) begin
            // Literal from bits 11:4 [RL3] [RL9]
            y = {8'h00, word[11:4]};
        end
        // Borrow style carries: set when the subtract underflows
        diff = {1'b0, x} - {1'b0, y};
        nib = {1'b0, x[3:0]} - {1'b0, y[3:0]};
        borrow = diff[16];
        half = nib[4];
        // One result serves sign and zero; carries come from diff and nib [RL20]
        if (op == mctc_pkg::OP_TST_LIT || op == mctc_pkg::OP_TST_B ||
            op == mctc_pkg::OP_TST_W) begin
            res = x & y;
        end else begin
            res = diff[15:0];
        end
        // Sign and zero from 16 or 8 bits [RL8]
        if (is_word) begin
            neg = res[15];
            zero = (res == 16'h0000);
            sgn_x = x[15];
            sgn_y = y[15];
        end else begin
            neg = res[7];
            zero = (res[7:0] == 8'h00);
            sgn_x = x[7];
            sgn_y = y[7];
        end
        ovf = (sgn_x != sgn_y) && (neg != sgn_x);
        // Flag select from bits 4, 5 and 7 [RL16]
        sel = '0;
        sel[mctc_pkg::IRQ_TRACE] = word[mctc_pkg::SEL_TRACE];
        sel[mctc_pkg::IRQ_PSW7] = word[mctc_pkg::SEL_PSW7];
        sel[mctc_pkg::IRQ_EXTTST] = word[mctc_pkg::SEL_EXTTST];
    end

    // Next state: execution unit and AXI slave
    always_comb begin
        d = q;
        d.ex_vld = 1'b0;
        wa = 8'h00;
        ra = 8'h00;

        // Execute one word per valid microcycle
        if (fire) begin
            d.ex_vld = 1'b1;
            d.ibus = word;
            d.mod_pend = 1'b0;
            case (op)
                mctc_pkg::OP_MODIFY: begin
                    // Capture B:A, register file untouched [RL1] [RL2]
                    d.mod_pend = 1'b1;
                    d.mod_word = {q.rf[b_idx], q.rf[a_idx]};
                end
                mctc_pkg::OP_CMP_LIT,
                mctc_pkg::OP_CMP_B,
                mctc_pkg::OP_CMP_W: begin
                    // Four status bits [RL3] [RL4] [RL5] [RL7]
                    d.stat[mctc_pkg::ST_NEG] = neg;
                    d.stat[mctc_pkg::ST_ZRO] = zero;
                    d.stat[mctc_pkg::ST_HC] = half;
                    d.stat[mctc_pkg::ST_CY] = borrow;
                    // Codes only in flags forms [RL6] [RL13]
                    if (flg_form) begin
                        d.cc[mctc_pkg::CC_N] = neg;
                        d.cc[mctc_pkg::CC_Z] = zero;
                        d.cc[mctc_pkg::CC_V] = ovf;
                        d.cc[mctc_pkg::CC_C] = borrow;
                    end
                end
                mctc_pkg::OP_TST_LIT,
                mctc_pkg::OP_TST_B,
                mctc_pkg::OP_TST_W: begin
                    // Carries kept [RL9] [RL10] [RL12]
                    d.stat[mctc_pkg::ST_NEG] = neg;
                    d.stat[mctc_pkg::ST_ZRO] = zero;
                    if (flg_form) begin
                        // C kept, V cleared [RL11] [RL13]
                        d.cc[mctc_pkg::CC_N] = neg;
                        d.cc[mctc_pkg::CC_Z] = zero;
                        d.cc[mctc_pkg::CC_V] = 1'b0;
                    end
                end
                mctc_pkg::OP_CLR_IRQ: begin
                    // Clear selected flags [RL14] [RL16]
                    d.irq = q.irq & ~sel;
                end
                mctc_pkg::OP_SET_IRQ: begin
                    // Set selected flags [RL15] [RL16]
                    d.irq = q.irq | sel;
                end
                mctc_pkg::OP_CLR_XST: begin
                    // All three bits to zero [RL17]
                    d.xst = mctc_pkg::RST_BITS3;
                end
                mctc_pkg::OP_IDLE: begin
                    // Nothing changes beyond the microcycle [RL19]
                    d.xst = q.xst;
                end
                default: begin
                    // Unknown words belong to other units
                    d.xst = q.xst;
                end
            endcase
        end

        // Write address channel
        if (s_axi_awvalid && q.awrdy) begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        // Write data channel
        if (s_axi_wvalid && q.wrdy) begin
            d.w_have = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        // Perform write once both halves are held
        if (q.aw_have && q.w_have && !q.bvld) begin
            wa = q.aw_addr;
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvld = 1'b1;
            d.bresp = mctc_pkg::RESP_OKAY;
            if (wa[7:6] == mctc_pkg::RF_SEL) begin
                // Register file byte in lane 0
                if (q.wstrb[0]) begin
                    d.rf[wa[5:2]] = q.wdata[7:0];
                end
            end else if (wa == mctc_pkg::ADDR_CTRL) begin
                if (q.wstrb[0]) begin
                    d.en = q.wdata[mctc_pkg::CTRL_EN];
                end
            end else if (wa == mctc_pkg::ADDR_XST) begin
                // Software load wins over a same-cycle clear
                if (q.wstrb[0]) begin
                    d.xst = q.wdata[2:0];
                end
            end else if (wa != mctc_pkg::ADDR_STATUS &&
                         wa != mctc_pkg::ADDR_IBUS) begin
                d.bresp = mctc_pkg::RESP_SLVERR;
            end else begin
                d.bresp = mctc_pkg::RESP_SLVERR;
            end
        end
        if (q.bvld && s_axi_bready) begin
            d.bvld = 1'b0;
        end
        d.awrdy = !d.aw_have;
        d.wrdy = !d.w_have;

        // Read channel
        if (s_axi_arvalid && q.arrdy) begin
            ra = s_axi_araddr;
            d.rvld = 1'b1;
            d.rresp = mctc_pkg::RESP_OKAY;
            d.rdata = 32'h0000_0000;
            if (ra[7:6] == mctc_pkg::RF_SEL) begin
                d.rdata[7:0] = q.rf[ra[5:2]];
            end else if (ra == mctc_pkg::ADDR_STATUS) begin
                d.rdata[mctc_pkg::SW_STAT_LSB +: 4] = q.stat;
                d.rdata[mctc_pkg::SW_CC_LSB +: 4] = q.cc;
                d.rdata[mctc_pkg::SW_XST_LSB +: 3] = q.xst;
                d.rdata[mctc_pkg::SW_IRQ_LSB +: 3] = q.irq;
                d.rdata[mctc_pkg::SW_PEND] = q.mod_pend;
            end else if (ra == mctc_pkg::ADDR_CTRL) begin
                d.rdata[mctc_pkg::CTRL_EN] = q.en;
            end else if (ra == mctc_pkg::ADDR_XST) begin
                d.rdata[2:0] = q.xst;
            end else if (ra == mctc_pkg::ADDR_IBUS) begin
                d.rdata[15:0] = q.ibus;
            end else begin
                d.rresp = mctc_pkg::RESP_SLVERR;
            end
        end
        if (q.rvld && s_axi_rready) begin
            d.rvld = 1'b0;
        end
        d.arrdy = !d.rvld;
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
            q.stat <= mctc_pkg::RST_FLAGS;
            q.cc <= mctc_pkg::RST_FLAGS;
            q.irq <= mctc_pkg::RST_BITS3;
            q.xst <= mctc_pkg::RST_BITS3;
            q.en <= mctc_pkg::RST_EN;
            q.awrdy <= 1'b1;
            q.wrdy <= 1'b1;
            q.arrdy <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from state flops
    assign instruction_bus_o = q.ibus;
    assign exec_valid_o = q.ex_vld;
    assign status_bits_o = q.stat;
    assign cond_codes_o = q.cc;
    assign irq_flags_o = q.irq;
    assign translation_state_bits_o = q.xst;
    assign s_axi_awready = q.awrdy;
    assign s_axi_wready = q.wrdy;
    assign s_axi_bvalid = q.bvld;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arrdy;
    assign s_axi_rvalid = q.rvld;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

endmodule

/* pkg/mctc_pkg.sv */
// Shared constants for the compare/test/control microinstruction unit
package mctc_pkg;

    // Microinstruction and data widths
    localparam int RF_DEPTH = 16;
    localparam int RF_IDX_W = 4;
    localparam int AXI_AW = 8;

    // Opcode prefixes on bits 15:12 (literal forms)
    localparam logic [3:0] OPC_CMP_LIT = 4'h3;
    localparam logic [3:0] OPC_TST_LIT = 4'h5;

    // Opcode prefixes on bits 15:8
    localparam logic [7:0] OPC_MODIFY = 8'hec;
    localparam logic [7:0] OPC_CMP_B = 8'hb4;
    localparam logic [7:0] OPC_CMP_BF = 8'hb5;
    localparam logic [7:0] OPC_CMP_W = 8'hb6;
    localparam logic [7:0] OPC_CMP_WF = 8'hb7;
    localparam logic [7:0] OPC_TST_B = 8'hc4;
    localparam logic [7:0] OPC_TST_BF = 8'hc5;
    localparam logic [7:0] OPC_TST_W = 8'hc6;
    localparam logic [7:0] OPC_TST_WF = 8'hc7;
    localparam logic [7:0] OPC_CLR_IRQ = 8'h70;
    localparam logic [7:0] OPC_SET_IRQ = 8'h71;
    localparam logic [7:0] OPC_CLR_XST = 8'h74;
    localparam logic [7:0] OPC_IDLE = 8'hff;

    // Instruction bits selecting the internal interrupt flags
    localparam int SEL_TRACE = 4;
    localparam int SEL_PSW7 = 5;
    localparam int SEL_EXTTST = 7;

    // Positions in the internal interrupt flag vector
    localparam int IRQ_TRACE = 0;
    localparam int IRQ_PSW7 = 1;
    localparam int IRQ_EXTTST = 2;

    // Status bit positions: negative, zero, half carry, carry
    localparam int ST_NEG = 3;
    localparam int ST_ZRO = 2;
    localparam int ST_HC = 1;
    localparam int ST_CY = 0;

    // Condition code positions
    localparam int CC_N = 3;
    localparam int CC_Z = 2;
    localparam int CC_V = 1;
    localparam int CC_C = 0;

    // Register byte addresses
    localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h00;
    localparam logic [AXI_AW-1:0] ADDR_CTRL = 8'h04;
    localparam logic [AXI_AW-1:0] ADDR_XST = 8'h08;
    localparam logic [AXI_AW-1:0] ADDR_IBUS = 8'h0c;
    localparam logic [AXI_AW-1:0] ADDR_RF_BASE = 8'h40;
    localparam logic [1:0] RF_SEL = 2'h1;

    // Status word field positions
    localparam int SW_STAT_LSB = 0;
    localparam int SW_CC_LSB = 4;
    localparam int SW_XST_LSB = 8;
    localparam int SW_IRQ_LSB = 12;
    localparam int SW_PEND = 16;

    // Control register bits
    localparam int CTRL_EN = 0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Reset values
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [2:0] RST_BITS3 = 3'h0;
    localparam logic RST_EN = 1'b0;

    // Decoded operation classes
    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_MODIFY = 4'b0001,
        OP_CMP_LIT = 4'b0010,
        OP_CMP_B = 4'b0011,
        OP_CMP_W = 4'b0100,
        OP_TST_LIT = 4'b0101,
        OP_TST_B = 4'b0110,
        OP_TST_W = 4'b0111,
        OP_CLR_IRQ = 4'b1000,
        OP_SET_IRQ = 4'b1001,
        OP_CLR_XST = 4'b1010,
        OP_IDLE = 4'b1011
    } mctc_op_t;

endpackage

/* verif/mctc_chk.sv */
`timescale 1ns/1ps
// Concurrent checks on each executed microword
module mctc_chk (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic cs_valid_i,
    input wire logic [15:0] instruction_bus_o,
    input wire logic exec_valid_o,
    input wire logic [3:0] status_bits_o,
    input wire logic [3:0] cond_codes_o,
    input wire logic [2:0] irq_flags_o,
    input wire logic [2:0] translation_state_bits_o
);
    logic [7:0] op;  // Opcode byte of executed word
    logic [3:0] hi;  // Literal-form opcode nibble
    logic [2:0] sel;  // Flag selectors in irq flag order
    logic cmp_f;  // Compare form with code update
    logic tst_f;  // Test form with code update
    logic plain;  // Compare or test without code update
    // Decode of the executed word
    assign op = instruction_bus_o[15:8];
    assign hi = instruction_bus_o[15:12];
    assign sel = {instruction_bus_o[7], instruction_bus_o[5:4]};
    assign cmp_f = exec_valid_o && (op == mctc_pkg::OPC_CMP_BF ||
        op == mctc_pkg::OPC_CMP_WF);
    assign tst_f = exec_valid_o && (op == mctc_pkg::OPC_TST_BF ||
        op == mctc_pkg::OPC_TST_WF);
    assign plain = exec_valid_o && op inside {mctc_pkg::OPC_CMP_B,
        mctc_pkg::OPC_CMP_W, mctc_pkg::OPC_TST_B, mctc_pkg::OPC_TST_W};
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    exec_cause_a: assert property (
        exec_valid_o |-> $past(cs_valid_i))
        else $error("execute pulse without offered word");
    idle_keep_a: assert property (
        exec_valid_o && op == mctc_pkg::OPC_IDLE |-> $stable(status_bits_o)
        && $stable(cond_codes_o) && $stable(irq_flags_o)
        && $stable(translation_state_bits_o))
        else $error("idle word changed state");
    cmp_lit_cc_a: assert property (
        exec_valid_o && hi == mctc_pkg::OPC_CMP_LIT |-> $stable(cond_codes_o))
        else $error("literal compare changed codes");
    tst_lit_keep_a: assert property (
        exec_valid_o && hi == mctc_pkg::OPC_TST_LIT
        |-> $stable(status_bits_o[1:0]) && $stable(cond_codes_o))
        else $error("literal test changed carries or codes");
    plain_cc_a: assert property (
        plain |-> $stable(cond_codes_o))
        else $error("plain form changed codes");
    tst_flags_a: assert property (
        tst_f |-> cond_codes_o[3:2] == status_bits_o[3:2]
        && !cond_codes_o[1] && cond_codes_o[0] == $past(cond_codes_o[0])
        && $stable(status_bits_o[1:0]))
        else $error("test flags form codes wrong");
    cmp_flags_a: assert property (
        cmp_f |-> cond_codes_o[3:2] == status_bits_o[3:2]
        && cond_codes_o[0] == status_bits_o[0])
        else $error("compare flags form codes disagree");
    set_irq_a: assert property (
        exec_valid_o && op == mctc_pkg::OPC_SET_IRQ
        |-> irq_flags_o == ($past(irq_flags_o) | sel) && $stable(cond_codes_o))
        else $error("set of internal flags wrong");
    clr_irq_a: assert property (
        exec_valid_o && op == mctc_pkg::OPC_CLR_IRQ
        |-> irq_flags_o == ($past(irq_flags_o) & ~sel)
        && $stable(status_bits_o))
        else $error("clear of internal flags wrong");
    clr_xst_a: assert property (
        exec_valid_o && op == mctc_pkg::OPC_CLR_XST
        |-> translation_state_bits_o == 3'h0 && $stable(cond_codes_o))
        else $error("translation bits not cleared");
    // Main scenarios reached
    cmp_flags_c: cover property (cmp_f);
    tst_flags_c: cover property (tst_f);
    set_irq_c: cover property (exec_valid_o && op == mctc_pkg::OPC_SET_IRQ);
endmodule
bind mctc_top mctc_chk i_chk (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .cs_valid_i(cs_valid_i),
    .instruction_bus_o(instruction_bus_o),
    .exec_valid_o(exec_valid_o),
    .status_bits_o(status_bits_o),
    .cond_codes_o(cond_codes_o),
    .irq_flags_o(irq_flags_o),
    .translation_state_bits_o(translation_state_bits_o)
);

/* verif/mctc_cstore.sv */
`timescale 1ns/1ps
// Control store model: hands out words back to back on request
module mctc_cstore (
    input wire logic ref_clk_i,
    output logic [15:0] cs_word_o,
    output logic cs_valid_o
);
    logic [15:0] mem_q [32];  // Stored microwords
    int ptr_q = 0;  // Next word to hand out
    int lim = 0;  // Words released so far
    // Place one word in the store
    task automatic load(input int a, input logic [15:0] w);
        mem_q[a] = w;
    endtask
    // Release n further words, away from the sampling edge
    task automatic run(input int n);
        @(negedge ref_clk_i);
        lim = ptr_q + n;
    endtask
    initial begin
        cs_word_o = 16'h0000;
        cs_valid_o = 1'b0;
    end
    // One word a cycle; outside frames the word toggles, never stale
    always @(posedge ref_clk_i) begin
        if (ptr_q < lim) begin
            cs_word_o <= mem_q[ptr_q];
            cs_valid_o <= 1'b1;
            ptr_q <= ptr_q + 1;
        end else begin
            cs_word_o <= ~cs_word_o;
            cs_valid_o <= 1'b0;
        end
    end
endmodule

/* verif/micro_compare_test_control_tb.sv */
`timescale 1ns/1ps
// Bench: registers over the bus, words from the store model
module micro_compare_test_control_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] cs_word, ibus;
    logic cs_valid, exec_v;
    logic [3:0] st, cc;
    logic [2:0] irq, xst;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int n_mismatch = 0;
    int n_checks = 0;
    // Register file bytes and program rows {word, bus, flags}
    localparam logic [7:0] RFV [16] = '{8'h80, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'hff, 8'h00, 8'h81, 8'h00, 8'h01, 8'h00,
        8'h00, 8'h80, 8'h00, 8'h80};
    localparam logic [47:0] PROG [20] = '{48'h3800_3800_4005,
        48'hb564_b564_3105, 48'hb780_b780_b905, 48'hc5a0_c5a0_7505,
        48'hb5a0_b5a0_2205, 48'hc7ec_c7ec_a805, 48'h57e0_57e0_6805,
        48'hb4a0_b4a0_2805, 48'hb680_b680_b805, 48'hc4a0_c4a0_7805,
        48'hc6ec_c6ec_b805, 48'h71b0_71b0_b875, 48'h7010_7010_b865,
        48'h7020_7020_b845, 48'h7080_7080_b805, 48'h7120_7120_b825,
        48'hec4a_0000_0000, 48'h3800_3801_9825, 48'h7400_7400_9820,
        48'hff00_ff00_9820};  // Ends with translation bits cleared
    always #2 clk = ~clk;
    mctc_cstore i_cs (.ref_clk_i(clk), .cs_word_o(cs_word),
        .cs_valid_o(cs_valid));
    mctc_top i_dut (.ref_clk_i(clk), .nrst_i(nrst), .cs_word_i(cs_word),
        .cs_valid_i(cs_valid), .instruction_bus_o(ibus),
        .exec_valid_o(exec_v), .status_bits_o(st), .cond_codes_o(cc),
        .irq_flags_o(irq), .translation_state_bits_o(xst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Bus write, address and data offered together
    task automatic wrchk(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask
    // Bus read with expected data and response
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
    endtask
    // Main sequence
    initial begin
        int k;
        k = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rdchk(mctc_pkg::ADDR_STATUS, 32'h0, mctc_pkg::RESP_OKAY);
        rdchk(mctc_pkg::ADDR_CTRL, 32'h0, mctc_pkg::RESP_OKAY);
        rdchk(8'h20, 32'h0, mctc_pkg::RESP_SLVERR);
        wrchk(mctc_pkg::ADDR_STATUS, 32'h1, mctc_pkg::RESP_SLVERR);
        $display("test reset_map done");
        // Words offered while disabled are ignored
        i_cs.load(0, 16'h3800);
        i_cs.run(1);
        repeat (4) begin
            @(posedge clk);
            #1;
            if (exec_v !== 1'b0) k++;
        end
        chk(k, 0);
        chk({28'h0, st}, 32'h0);
        $display("test disabled done");
        for (int i = 0; i < 16; i++) begin
            wrchk(mctc_pkg::ADDR_RF_BASE + 8'(4 * i), {24'h0, RFV[i]},
                mctc_pkg::RESP_OKAY);
        end
        wrchk(mctc_pkg::ADDR_XST, 32'h5, mctc_pkg::RESP_OKAY);
        wrchk(mctc_pkg::ADDR_CTRL, 32'h1, mctc_pkg::RESP_OKAY);
        for (int i = 0; i < 20; i++) i_cs.load(i + 1, PROG[i][47:32]);
        i_cs.run(20);
        k = 0;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (exec_v === 1'b1 && ibus[15:8] !== mctc_pkg::OPC_MODIFY) begin
                if (PROG[k][47:40] == mctc_pkg::OPC_MODIFY) k++;
                chk(ibus, PROG[k][31:16]);
                chk({st, cc}, PROG[k][15:8]);
                chk({1'b0, irq, 1'b0, xst}, PROG[k][7:0]);
                k++;
            end
        end
        chk(k, 20);
        $display("test program done");
        for (int i = 0; i < 16; i++) begin
            rdchk(mctc_pkg::ADDR_RF_BASE + 8'(4 * i), {24'h0, RFV[i]},
                mctc_pkg::RESP_OKAY);
        end
        rdchk(mctc_pkg::ADDR_STATUS, 32'h2089, mctc_pkg::RESP_OKAY);
        rdchk(mctc_pkg::ADDR_IBUS, 32'hff00, mctc_pkg::RESP_OKAY);
        $display("test readback done");
        conclude();
    end
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
endmodule
